// *** logic/hmc_pkg.sv ***
// package for the halt mode clock gating controller
// assumes a single 20 MHz clock domain
`default_nettype none
package hmc_pkg;
  // cpu clock source encoding
  localparam logic [1:0] SRC_MAIN = 2'h0;
  localparam logic [1:0] SRC_RING = 2'h1;
  localparam logic [1:0] SRC_SUB  = 2'h2;
  // byte timer count clock select encoding
  localparam logic [1:0] TSEL_EXT   = 2'h0;
  localparam logic [1:0] TSEL_INT   = 2'h1;
  localparam logic [1:0] TSEL_CHAIN = 2'h2;
  // watch timer source select encoding
  localparam logic [1:0] WSEL_MAIN = 2'h0;
  localparam logic [1:0] WSEL_SUB  = 2'h1;
  localparam logic [1:0] WSEL_RING = 2'h2;
  localparam int PORT_W = 8;
  localparam logic [7:0] PORT_RST = 8'h00;

  typedef enum logic [1:0]
  {
    HMC_RUN  = 2'b01,
    HMC_HALT = 2'b10
  } hmc_state_t;
endpackage : hmc_pkg
`default_nettype wire

// *** logic/hmc_halt_ctrl.sv ***
// halt mode controller: gates the cpu clock and qualifies timer clocks in halt
// assumes the cpu core issues a one-cycle halt strobe and a same-clock wake level
`timescale 1ns/1ns
`default_nettype none
module hmc_halt_ctrl
(
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_halt_instr,
  input  wire logic                         i_wake,
  input  wire logic [1:0]                   i_cpu_clk_src,
  input  wire logic                         i_sub_clk_used,
  input  wire logic                         i_ring_stop_req,
  input  wire logic                         i_ring_stoppable_opt,
  input  wire logic [1:0]                   i_tmr0_sel,
  input  wire logic [1:0]                   i_tmr1_sel,
  input  wire logic [1:0]                   i_tmh0_sel,
  input  wire logic                         i_tmr0_running,
  input  wire logic [1:0]                   i_watch_sel,
  input  wire logic [hmc_pkg::PORT_W-1:0]   i_port_d,
  output logic                              o_cpu_clk_en,
  output logic                              o_halted,
  output logic [hmc_pkg::PORT_W-1:0]        o_port_q,
  output logic                              o_tmr16_en,
  output logic                              o_tmr0_en,
  output logic                              o_tmr1_en,
  output logic                              o_tmh0_en,
  output logic                              o_watch_en,
  output logic                              o_wdt_en,
  output logic                              o_ring_run
);

  // ***************************************************
  // state
  // ***************************************************
  hmc_pkg::hmc_state_t               state_q, state_d;
  logic [1:0]                        src_q, src_d;
  logic                              sub_q, sub_d;
  logic                              ring_run_q, ring_run_d;
  logic [hmc_pkg::PORT_W-1:0]        port_q, port_d;
  logic                              cpu_en_q, cpu_en_d;
  logic                              halted_q, halted_d;
  logic                              t16_q, t16_d;
  logic                              t0_q, t0_d;
  logic                              t1_q, t1_d;
  logic                              th_q, th_d;
  logic                              wt_q, wt_d;
  logic                              wd_q, wd_d;

  // ***************************************************
  // decode helpers
  // ***************************************************
  function automatic logic ext_ok(input logic [1:0] sel);
    ext_ok = (sel == hmc_pkg::TSEL_EXT);
  endfunction : ext_ok

  function automatic logic src_ok(input logic [1:0] src);
    src_ok = (src == hmc_pkg::SRC_MAIN) || (src == hmc_pkg::SRC_RING) ||
             (src == hmc_pkg::SRC_SUB);
  endfunction : src_ok

  function automatic logic watch_ok
  (
    input logic [1:0] src,
    input logic       sub,
    input logic [1:0] sel
  );
    if (src == hmc_pkg::SRC_RING)
    begin
      watch_ok = sub && (sel == hmc_pkg::WSEL_SUB);
    end
    else if (src == hmc_pkg::SRC_MAIN && !sub)
    begin
      watch_ok = (sel == hmc_pkg::WSEL_MAIN);
    end
    else
    begin
      // main with subclock, or cpu on subclock
      watch_ok = 1'b1;
    end
  endfunction : watch_ok

  // ***************************************************
  // next state
  // ***************************************************
  always_comb
  begin
    state_d    = state_q;
    src_d      = src_q;
    sub_d      = sub_q;
    port_d     = port_q;
    ring_run_d = ring_run_q;
    // ring can only stop when the option allows it
    if (state_q == hmc_pkg::HMC_RUN)
    begin
      ring_run_d = !(i_ring_stoppable_opt && i_ring_stop_req);
    end
    case (state_q)
      hmc_pkg::HMC_RUN:
      begin
        port_d = i_port_d;
        // any of the three cpu clock sources may enter halt
        if (i_halt_instr && src_ok(i_cpu_clk_src))
        begin
          state_d = hmc_pkg::HMC_HALT;
          src_d   = i_cpu_clk_src;
          sub_d   = i_sub_clk_used;
        end
      end
      hmc_pkg::HMC_HALT:
      begin
        // port latch frozen while halted
        port_d = port_q;
        if (i_wake)
        begin
          state_d = hmc_pkg::HMC_RUN;
        end
      end
      default:
      begin
        state_d = hmc_pkg::HMC_RUN;
      end
    endcase
  end

  // ***************************************************
  // clock qualification
  // ***************************************************
  always_comb
  begin
    logic halt_n;
    logic ring;
    halt_n = (state_d != hmc_pkg::HMC_HALT);
    ring   = (src_d == hmc_pkg::SRC_RING);
    cpu_en_d = halt_n;
    halted_d = !halt_n;
    if (halt_n)
    begin
      t16_d = 1'b1;
      t0_d  = 1'b1;
      t1_d  = 1'b1;
      th_d  = 1'b1;
      wt_d  = 1'b1;
    end
    else
    begin
      t16_d = (src_d == hmc_pkg::SRC_MAIN);
      t0_d  = !ring || ext_ok(i_tmr0_sel);
      t1_d  = !ring || ext_ok(i_tmr1_sel);
      th_d  = !ring || (i_tmh0_sel == hmc_pkg::TSEL_CHAIN && i_tmr0_running);
      wt_d  = watch_ok(src_d, sub_d, i_watch_sel);
    end
    // watchdog runs off the ring, which runs unless stopped by option
    wd_d = ring_run_d;
  end

  // ***************************************************
  // register stage
  // ***************************************************
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_q    <= hmc_pkg::HMC_RUN;
      src_q      <= hmc_pkg::SRC_MAIN;
      sub_q      <= 1'b0;
      ring_run_q <= 1'b1;
      port_q     <= hmc_pkg::PORT_RST;
      cpu_en_q   <= 1'b1;
      halted_q   <= 1'b0;
      t16_q      <= 1'b1;
      t0_q       <= 1'b1;
      t1_q       <= 1'b1;
      th_q       <= 1'b1;
      wt_q       <= 1'b1;
      wd_q       <= 1'b1;
    end
    else
    begin
      state_q    <= state_d;
      src_q      <= src_d;
      sub_q      <= sub_d;
      ring_run_q <= ring_run_d;
      port_q     <= port_d;
      cpu_en_q   <= cpu_en_d;
      halted_q   <= halted_d;
      t16_q      <= t16_d;
      t0_q       <= t0_d;
      t1_q       <= t1_d;
      th_q       <= th_d;
      wt_q       <= wt_d;
      wd_q       <= wd_d;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign o_cpu_clk_en = cpu_en_q;
  assign o_halted     = halted_q;
  assign o_port_q     = port_q;
  assign o_tmr16_en   = t16_q;
  assign o_tmr0_en    = t0_q;
  assign o_tmr1_en    = t1_q;
  assign o_tmh0_en    = th_q;
  assign o_watch_en   = wt_q;
  assign o_wdt_en     = wd_q;
  assign o_ring_run   = ring_run_q;

endmodule : hmc_halt_ctrl
`default_nettype wire

// *** sim/hmc_halt_ctrl_assertions.sv ***
// checker for the halt mode controller
// assumes it is bound onto hmc_halt_ctrl
`timescale 1ns/1ns
`default_nettype none
module hmc_chk
(
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_halt_instr,
  input wire logic       i_wake,
  input wire logic [1:0] i_cpu_clk_src,
  input wire logic [7:0] i_port_d,
  input wire logic       i_ring_stop_req,
  input wire logic       i_ring_stoppable_opt,
  input wire logic       o_cpu_clk_en,
  input wire logic       o_halted,
  input wire logic [7:0] o_port_q,
  input wire logic       o_tmr16_en,
  input wire logic       o_wdt_en,
  input wire logic       o_ring_run
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_halt_entry: assert property (
    !o_halted && i_halt_instr && i_cpu_clk_src != 2'h3 |=> o_halted) else $error("no halt");
  a_bad_src: assert property (
    !o_halted && i_cpu_clk_src == 2'h3 |=> !o_halted) else $error("bad source halted");
  a_clk_gated: assert property (o_cpu_clk_en != o_halted) else $error("cpu clock on");
  a_port_hold: assert property (o_halted |=> $stable(o_port_q)) else $error("port moved");
  a_port_take: assert property (
    !o_halted |=> o_port_q == $past(i_port_d)) else $error("port not taken");
  a_wake_up: assert property (
    o_halted && i_wake |=> !o_halted ##0 o_tmr16_en) else $error("no wake");
  a_ring_tmr16: assert property (
    !o_halted && i_halt_instr && i_cpu_clk_src == hmc_pkg::SRC_RING |=> !o_tmr16_en)
    else $error("tmr16 on");
  a_wdt_ring: assert property (o_wdt_en == o_ring_run) else $error("wdt mismatch");
  a_ring_stop: assert property (
    !o_halted && i_ring_stoppable_opt && i_ring_stop_req |=> !o_ring_run)
    else $error("ring not stopped");
  a_ring_fixed: assert property (
    !o_halted && !i_ring_stoppable_opt |=> o_ring_run) else $error("ring stopped");
  a_ring_frozen: assert property (
    o_halted |=> $stable(o_ring_run)) else $error("ring state moved in halt");
  cover property (o_halted && i_wake);
  cover property (!o_ring_run);
  cover property (i_halt_instr && i_cpu_clk_src == 2'h3);
endmodule : hmc_chk
bind hmc_halt_ctrl hmc_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_halt_instr(i_halt_instr),
  .i_wake(i_wake), .i_cpu_clk_src(i_cpu_clk_src), .i_port_d(i_port_d),
  .i_ring_stop_req(i_ring_stop_req), .i_ring_stoppable_opt(i_ring_stoppable_opt),
  .o_cpu_clk_en(o_cpu_clk_en), .o_halted(o_halted), .o_port_q(o_port_q),
  .o_tmr16_en(o_tmr16_en), .o_wdt_en(o_wdt_en), .o_ring_run(o_ring_run));
`default_nettype wire

// *** sim/hmc_cpu_model.sv ***
// cpu core model: halt strobe on request, port bus that never rests
// assumes the bench drives on the falling edge
`timescale 1ns/1ns
`default_nettype none
module hmc_cpu_model
(
  input  wire logic       i_clk,
  input  wire logic       i_cpu_clk_en,
  input  wire logic       i_req,
  output logic            o_halt_instr = 1'b0,
  output logic [7:0]      o_port_d = 8'h00
);
  // a gated core issues nothing; its port bus still changes
  always @(negedge i_clk)
  begin
    o_halt_instr <= i_req & i_cpu_clk_en;
    o_port_d     <= o_port_d + 8'h01;
  end
endmodule : hmc_cpu_model
`default_nettype wire

// *** sim/hmc_halt_ctrl_bench.sv ***
// self-checking bench for the halt mode controller
// assumes the cpu model drives halt strobe and port data
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t %h %h", $time, a, e); end end
module hmc_halt_ctrl_bench;
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, wake = 1'b0;
  logic sub = 1'b0, stp = 1'b0, opt = 1'b0, run = 1'b0;
  logic [1:0] src = 2'h0, s0 = 2'h0, s1 = 2'h0, hs = 2'h0, ws = 2'h0;
  logic [7:0] pd, pq, hold;
  logic en, hlt, t16, t0, t1, th, we, wd, rr, hi;
  // src sub sel0 sel1 hsel run wsel | tmr16 tmr0 tmr1 tmh0 watch
  logic [35:0] rows [6] = '{36'h00111001f, 36'h00000011e, 36'h11012110b,
                            36'h111020004, 36'h102211100, 36'h21110020f};
  int error_cnt = 0, total_checks = 0, cyc = 0;
  always #25 clk = ~clk;
  hmc_cpu_model u_hmc_cpu_model (.i_clk(clk), .i_cpu_clk_en(en), .i_req(req),
    .o_halt_instr(hi), .o_port_d(pd));
  hmc_halt_ctrl u_hmc_halt_ctrl (.i_clk(clk), .i_rst(rst), .i_halt_instr(hi), .i_wake(wake),
    .i_cpu_clk_src(src), .i_sub_clk_used(sub), .i_ring_stop_req(stp),
    .i_ring_stoppable_opt(opt), .i_tmr0_sel(s0), .i_tmr1_sel(s1), .i_tmh0_sel(hs),
    .i_tmr0_running(run), .i_watch_sel(ws), .i_port_d(pd), .o_cpu_clk_en(en),
    .o_halted(hlt), .o_port_q(pq), .o_tmr16_en(t16), .o_tmr0_en(t0), .o_tmr1_en(t1),
    .o_tmh0_en(th), .o_watch_en(we), .o_wdt_en(wd), .o_ring_run(rr));
  task automatic report_and_stop;
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic halt;
    req <= 1'b1; step(1); req <= 1'b0; step(1);
  endtask : halt
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000) begin error_cnt++; report_and_stop(); end
  end
  initial
  begin
    step(6);
    `CHK({en, hlt, pq, t16, t0, t1, th, we, wd, rr}, 17'h1007f)
    rst <= 1'b0; step(1);
    `CHK(pq, pd)
    foreach (rows[i])
    begin
      src = rows[i][33:32]; sub = rows[i][28]; s0 = rows[i][25:24]; s1 = rows[i][21:20];
      hs = rows[i][17:16]; run = rows[i][12]; ws = rows[i][9:8];
      halt(); hold = pd;
      `CHK({hlt, en, t16}, {2'b10, rows[i][4]})
      `CHK({t0, t1, th, we}, rows[i][3:0])
      step(3); `CHK(pq, hold)
      wake <= 1'b1; step(1); wake <= 1'b0; step(1);
      `CHK({hlt, en, t16, t0, t1, th, we}, 7'h3f)
    end
    src = 2'h3; halt(); `CHK(hlt, 1'b0)
    opt = 1'b1; stp = 1'b1; step(2); `CHK({rr, wd}, 2'b00)
    opt = 1'b0; step(2); `CHK({rr, wd}, 2'b11)
    src = 2'h0; stp = 1'b0; halt(); opt = 1'b1; stp = 1'b1; step(2);
    `CHK({hlt, rr, wd}, 3'b111)
    rst <= 1'b1; step(1);
    `CHK({en, hlt, pq, t16, t0, t1, th, we, wd, rr}, 17'h1007f)
    rst <= 1'b0; opt = 1'b0; stp = 1'b0; step(1);
    `CHK(pq, pd)
    report_and_stop();
  end
endmodule : hmc_halt_ctrl_bench
`default_nettype wire
